// ===== iofer_reporter.v
/*
  Fault code generation and event reporting for the interface processor.
  Records each event in status words visible to the attached host
  processor and then pulses one interrupt line. Assumes event strobes
  come from logic on mclk; the host reads status over APB (the control
  window) and clears indicator fields by writing ones.
*/
// Decided for this implementation: the register offsets and the APB interface to the registers.
// Notes on behaviour
// - Record event, then pulse interrupt once
// - Every event handled alike, even back-to-back; the code merges events that arrive before the commit into one report
// - Normal completion reads 0000, maskable
// - Fault level 01 context, 10 process, 11 processor
// - Transfer state 01 count, 10 forced, 11 fault
// - Local/global message response indicators set
// - Alarm, reconfiguration, dispatch indicators set
// - Map operator fault codes 00 0100 to 00 1011
// - Mode-setting: rights 00 1101, illegal 00 1100
// - Dispatch: enqueued 00 1110, rights 00 1101
// - Copy without delete rights: 01 0011
// - Unlock mismatch 01 1001, rights 01 0110
// - Enter segment: range 01 0101, read 01 0110
// - Surrogate: carrier 01 0101, port 01 0110
// - Send-to-processor rights, lock, type-test codes
// - Init: lock 11 0001, base/mask 11 1000
// - Binding: lock 11 0001, carrier type 00001000
// - Type retrieval: 01 0101, type-test 00010111
// - General code: two-bit level, four-bit type
// - Type-test code: D, Q, class, expected value
`timescale 1ns/1ns
`include "iofer_consts.vh"

module iofer_reporter (
  // Clock and reset
  input  wire        mclk,
  input  wire        nrst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // Event inputs from processor logic
  input  wire        func_done,
  input  wire        fault_valid,
  input  wire [5:0]  fault_sel,
  input  wire        xfer_valid,
  input  wire [2:0]  xfer_win,
  input  wire [1:0]  xfer_kind,
  input  wire        rsp_valid,
  input  wire [4:0]  rsp_bits,
  // Interrupt to attached host processor
  output reg         host_irq
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_WRITE = 2'h1;
  localparam ST_PULSE = 2'h2;

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [3:0]  func_state_q;
  reg  [9:0]  entry_state_q;
  reg  [4:0]  resp_q;
  reg  [15:0] fault_code_q;
  reg  [15:0] evt_count_q;
  reg         cmpl_mask_q;
  reg         pend_done_q;
  reg         pend_fault_q;
  reg  [15:0] pend_code_q;
  reg         pend_xfer_q;
  reg  [2:0]  pend_win_q;
  reg  [1:0]  pend_kind_q;
  reg         pend_rsp_q;
  reg  [4:0]  pend_bits_q;
  reg  [15:0] code_d;

  wire wr_en = psel & penable & pwrite;
  wire rd_hit;
  wire commit  = (state_q == ST_WRITE);
  // Code level 00 must not read as 0000, the normal completion value
  wire [1:0] fault_lvl = (pend_code_q[5:4] == 2'h0) ? `IOFER_LVL_CONTEXT :
                         ((pend_code_q[5:4] == 2'h3) ? `IOFER_LVL_PROCESSOR :
                          `IOFER_LVL_PROCESS);

  assign pready  = 1'b1;
  assign rd_hit  = (paddr == `IOFER_OFF_CTRL) | (paddr == `IOFER_OFF_FUNC_STATE) |
                   (paddr == `IOFER_OFF_ENTRY_STATE) | (paddr == `IOFER_OFF_RESP) |
                   (paddr == `IOFER_OFF_FAULT_CODE) | (paddr == `IOFER_OFF_EVT_COUNT);
  assign pslverr = psel & penable & ~rd_hit;

  always @* begin
    code_d = 16'h0000;
    case (fault_sel)
      `IOFER_F_MAP_ICD:     code_d = {10'h000, `IOFER_E_MAP_ICD};
      `IOFER_F_MAP_VALID:   code_d = {10'h000, `IOFER_E_MAP_VALID};
      `IOFER_F_MAP_DIR:     code_d = {10'h000, `IOFER_E_MAP_DIR};
      `IOFER_F_MAP_LEN:     code_d = {10'h000, `IOFER_E_MAP_LEN};
      `IOFER_F_MAP_OVL:     code_d = {10'h000, `IOFER_E_MAP_OVL};
      `IOFER_F_MAP_BLK:     code_d = {10'h000, `IOFER_E_MAP_BLK};
      `IOFER_F_MAP_OPND:    code_d = {10'h000, `IOFER_E_MAP_OPND};
      `IOFER_F_MAP_FORCE:   code_d = {10'h000, `IOFER_E_MAP_FORCE};
      `IOFER_F_PSM_RIGHTS:  code_d = {10'h000, `IOFER_E_RIGHTS_CTX};
      `IOFER_F_PSM_ILLEGAL: code_d = {10'h000, `IOFER_E_ILLEGAL};
      `IOFER_F_DSP_ENQ:     code_d = {10'h000, `IOFER_E_ENQUEUED};
      `IOFER_F_DSP_RIGHTS:  code_d = {10'h000, `IOFER_E_RIGHTS_CTX};
      `IOFER_F_CPY_DELETE:  code_d = {10'h000, `IOFER_E_DELETE};
      `IOFER_F_UNL_ID:      code_d = {10'h000, `IOFER_E_LOCK_ID};
      `IOFER_F_LCK_RIGHTS:  code_d = {10'h000, `IOFER_E_RIGHTS};
      `IOFER_F_ENT_RANGE:   code_d = {10'h000, `IOFER_E_SRC_INVALID};
      `IOFER_F_ENT_READ:    code_d = {10'h000, `IOFER_E_RIGHTS};
      `IOFER_F_SUR_CARRIER: code_d = {10'h000, `IOFER_E_SRC_INVALID};
      `IOFER_F_SUR_PORT:    code_d = {10'h000, `IOFER_E_RIGHTS};
      `IOFER_F_STP_RIGHTS:  code_d = {10'h000, `IOFER_E_RIGHTS};
      `IOFER_F_STP_LOCK:    code_d = {10'h000, `IOFER_E_LOCK_ID};
      `IOFER_F_STP_TT_PAS:  code_d = {1'b0, `IOFER_TT_CLASS, 5'h00, `IOFER_T_PROC};
      `IOFER_F_STP_TT_COMM: code_d = {1'b0, `IOFER_TT_CLASS, 5'h00, `IOFER_T_COMM};
      `IOFER_F_INI_LOCK:    code_d = {10'h000, `IOFER_E_OBJ_LOCK};
      `IOFER_F_INI_MASK:    code_d = {10'h000, `IOFER_E_BASE_MASK};
      `IOFER_F_BND_LOCK:    code_d = {10'h000, `IOFER_E_OBJ_LOCK};
      `IOFER_F_BND_TT:      code_d = {1'b0, `IOFER_TT_CLASS, 5'h00, `IOFER_T_CARRIER};
      `IOFER_F_TYP_SRC:     code_d = {10'h000, `IOFER_E_SRC_INVALID};
      `IOFER_F_TYP_OTE:     code_d = {1'b0, `IOFER_TT_CLASS, 5'h00, `IOFER_T_OTE};
      default:              code_d = 16'h0000;
    endcase
  end

  // capture every event except completions while cmpl_mask_q is set, merging arrivals while busy
  always @(posedge mclk) begin
    if (!nrst) begin
      pend_done_q  <= 1'b0;
      pend_fault_q <= 1'b0;
      pend_code_q  <= 16'h0000;
      pend_xfer_q  <= 1'b0;
      pend_win_q   <= 3'h0;
      pend_kind_q  <= 2'h0;
      pend_rsp_q   <= 1'b0;
      pend_bits_q  <= 5'h00;
    end else begin
      pend_done_q  <= (pend_done_q & ~commit) | (func_done & ~cmpl_mask_q) |
                      (func_done & cmpl_mask_q & 1'b0);
      pend_fault_q <= (pend_fault_q & ~commit) | fault_valid;
      pend_xfer_q  <= (pend_xfer_q & ~commit) | xfer_valid;
      pend_rsp_q   <= (pend_rsp_q & ~commit) | rsp_valid;
      if (fault_valid)
        pend_code_q <= code_d;
      if (xfer_valid) begin
        pend_win_q  <= xfer_win;
        pend_kind_q <= xfer_kind;
      end
      if (rsp_valid)
        pend_bits_q <= (commit ? 5'h00 : pend_bits_q) | rsp_bits;
      else if (commit)
        pend_bits_q <= 5'h00;
    end
  end

  // Sequencer: write indicators, then pulse
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (pend_done_q | pend_fault_q | pend_xfer_q | pend_rsp_q) state_d = ST_WRITE;
      ST_WRITE: state_d = ST_PULSE;
      // Passing through idle holds host_irq low two cycles between pulses, keeping each one distinct
      ST_PULSE: state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always @(posedge mclk) begin
    if (!nrst) begin
      state_q  <= ST_IDLE;
      host_irq <= 1'b0;
    end else begin
      state_q  <= state_d;
      host_irq <= commit;
    end
  end

  // Status words; host write of ones clears function state and response indicators, hardware set wins
  always @(posedge mclk) begin
    if (!nrst) begin
      func_state_q  <= `IOFER_FS_IDLE;
      entry_state_q <= 10'h000;
      resp_q        <= 5'h00;
      fault_code_q  <= 16'h0000;
      evt_count_q   <= 16'h0000;
      cmpl_mask_q   <= 1'b0;
    end else begin
      if (wr_en && paddr == `IOFER_OFF_CTRL)
        cmpl_mask_q <= pwdata[`IOFER_CTRL_CMPL_MASK];
      if (commit && pend_fault_q) begin
        func_state_q <= {2'h0, fault_lvl};
        fault_code_q <= pend_code_q;
      end else if (commit && pend_done_q)
        func_state_q <= `IOFER_FS_DONE;
      else if (wr_en && paddr == `IOFER_OFF_FUNC_STATE && pwdata[0])
        func_state_q <= `IOFER_FS_IDLE;
      resp_q <= (resp_q & ~((wr_en && paddr == `IOFER_OFF_RESP) ? pwdata[4:0] : 5'h00))
                | ((commit && pend_rsp_q) ? pend_bits_q : 5'h00);
      if (commit)
        evt_count_q <= evt_count_q + 16'h0001;
    end
  end

  genvar w;
  generate
    for (w = 0; w < `IOFER_NWIN; w = w + 1) begin : g_win
      wire hit  = commit & pend_xfer_q & (pend_win_q == w) &
                  ((pend_kind_q == `IOFER_TS_FAULT) | (w == 0));
      wire clr  = wr_en & (paddr == `IOFER_OFF_ENTRY_STATE) & (|pwdata[2*w+1:2*w]);
      always @(posedge mclk) begin
        if (!nrst)
          entry_state_q[2*w+1:2*w] <= `IOFER_TS_NONE;
        else if (hit)
          entry_state_q[2*w+1:2*w] <= pend_kind_q;
        else if (clr)
          entry_state_q[2*w+1:2*w] <= `IOFER_TS_NONE;
      end
    end
  endgenerate

  always @* begin
    prdata = 32'h0000_0000;
    case (paddr)
      `IOFER_OFF_CTRL:        prdata = {31'h0, cmpl_mask_q};
      `IOFER_OFF_FUNC_STATE:  prdata = {28'h0, func_state_q};
      `IOFER_OFF_ENTRY_STATE: prdata = {22'h0, entry_state_q};
      `IOFER_OFF_RESP:        prdata = {27'h0, resp_q};
      `IOFER_OFF_FAULT_CODE:  prdata = {16'h0, fault_code_q};
      `IOFER_OFF_EVT_COUNT:   prdata = {16'h0, evt_count_q};
      default:                prdata = 32'h0000_0000;
    endcase
  end

endmodule

// ===== iofer_consts.vh
/*
  Constants for the fault event reporter: fault code layouts, encodings,
  indicator values and the layout of the status words it writes out.
  Assumes inclusion by bare name from the reporter module.
*/
`ifndef IOFER_CONSTS_VH
`define IOFER_CONSTS_VH

// APB register byte offsets
`define IOFER_OFF_CTRL        12'h000
`define IOFER_OFF_FUNC_STATE  12'h004
`define IOFER_OFF_ENTRY_STATE 12'h008
`define IOFER_OFF_RESP        12'h00C
`define IOFER_OFF_FAULT_CODE  12'h010
`define IOFER_OFF_EVT_COUNT   12'h014

// Control bits
`define IOFER_CTRL_CMPL_MASK  0
`define IOFER_CTRL_RESET      32'h0000_0001

// Function state values
`define IOFER_FS_DONE         4'h0
`define IOFER_FS_IDLE         4'hF
`define IOFER_LVL_CONTEXT     2'h1
`define IOFER_LVL_PROCESS     2'h2
`define IOFER_LVL_PROCESSOR   2'h3

// Transfer state values
`define IOFER_TS_NONE         2'h0
`define IOFER_TS_COUNT        2'h1
`define IOFER_TS_FORCED       2'h2
`define IOFER_TS_FAULT        2'h3
`define IOFER_NWIN            5

// Response indicator bit positions
`define IOFER_RSP_LOCAL       0
`define IOFER_RSP_GLOBAL      1
`define IOFER_RSP_ALARM       2
`define IOFER_RSP_RECONF      3
`define IOFER_RSP_DISPATCH    4

// General fault code: class bits [14:13] = 00, level [5:4], type [3:0]
`define IOFER_GEN_CLASS       2'h0
`define IOFER_TT_CLASS        2'h3

// Fault source selects (event codes on the fault port)
`define IOFER_F_MAP_ICD       6'h00
`define IOFER_F_MAP_VALID     6'h01
`define IOFER_F_MAP_DIR       6'h02
`define IOFER_F_MAP_LEN       6'h03
`define IOFER_F_MAP_OVL       6'h04
`define IOFER_F_MAP_BLK       6'h05
`define IOFER_F_MAP_OPND      6'h06
`define IOFER_F_MAP_FORCE     6'h07
`define IOFER_F_PSM_RIGHTS    6'h08
`define IOFER_F_PSM_ILLEGAL   6'h09
`define IOFER_F_DSP_ENQ       6'h0A
`define IOFER_F_DSP_RIGHTS    6'h0B
`define IOFER_F_CPY_DELETE    6'h0C
`define IOFER_F_UNL_ID        6'h0D
`define IOFER_F_LCK_RIGHTS    6'h0E
`define IOFER_F_ENT_RANGE     6'h0F
`define IOFER_F_ENT_READ      6'h10
`define IOFER_F_SUR_CARRIER   6'h11
`define IOFER_F_SUR_PORT      6'h12
`define IOFER_F_STP_RIGHTS    6'h13
`define IOFER_F_STP_LOCK      6'h14
`define IOFER_F_STP_TT_PAS    6'h15
`define IOFER_F_STP_TT_COMM   6'h16
`define IOFER_F_INI_LOCK      6'h17
`define IOFER_F_INI_MASK      6'h18
`define IOFER_F_BND_LOCK      6'h19
`define IOFER_F_BND_TT        6'h1A
`define IOFER_F_TYP_SRC       6'h1B
`define IOFER_F_TYP_OTE       6'h1C

// Six bit general encodings (level, type)
`define IOFER_E_MAP_ICD       6'h04
`define IOFER_E_MAP_VALID     6'h05
`define IOFER_E_MAP_DIR       6'h06
`define IOFER_E_MAP_LEN       6'h07
`define IOFER_E_MAP_OVL       6'h08
`define IOFER_E_MAP_BLK       6'h09
`define IOFER_E_MAP_OPND      6'h0A
`define IOFER_E_MAP_FORCE     6'h0B
`define IOFER_E_ILLEGAL       6'h0C
`define IOFER_E_RIGHTS_CTX    6'h0D
`define IOFER_E_ENQUEUED      6'h0E
`define IOFER_E_DELETE        6'h13
`define IOFER_E_SRC_INVALID   6'h15
`define IOFER_E_RIGHTS        6'h16
`define IOFER_E_LOCK_ID       6'h19
`define IOFER_E_OBJ_LOCK      6'h31
`define IOFER_E_BASE_MASK     6'h38

// Eight bit type test encodings: D, Q, PP, KKKKK in low byte
`define IOFER_T_PROC          8'h06
`define IOFER_T_COMM          8'h0A
`define IOFER_T_CARRIER       8'h08
`define IOFER_T_OTE           8'h17

`endif

// ===== iofer_reporter_monitor.sv
/*
  Port checker for the fault event reporter.
  Assumes binding onto the reporter's top module, one clock, reset low.
*/
`timescale 1ns/1ns
`include "iofer_consts.vh"

module iofer_reporter_monitor (
  // Clock and reset
  input logic        mclk,
  input logic        nrst,
  // APB
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic        pslverr,
  input logic [31:0] prdata,
  // Events and interrupt
  input logic        func_done,
  input logic        fault_valid,
  input logic [5:0]  fault_sel,
  input logic        xfer_valid,
  input logic [2:0]  xfer_win,
  input logic [1:0]  xfer_kind,
  input logic        rsp_valid,
  input logic [4:0]  rsp_bits,
  input logic        host_irq
);
  // Merged reports may push a pulse late, hence the loose bound
  logic [3:0] since_q;
  logic [3:0] since_d;
  logic       acc;
  assign acc = psel & penable;
  assign since_d = (func_done | fault_valid | xfer_valid | rsp_valid) ? 4'h0 :
                   ((since_q == 4'hF) ? since_q : since_q + 4'h1);
  always @(posedge mclk) begin
    if (!nrst) begin
      since_q <= 4'hF;
    end else begin
      since_q <= since_d;
    end
  end

  irq_one_cycle_a: assert property (@(posedge mclk) disable iff (!nrst) host_irq |=> !host_irq)
    else $error("interrupt wider than one cycle");
  irq_has_cause_a: assert property (@(posedge mclk) disable iff (!nrst) host_irq |-> since_q <= 4'hA)
    else $error("interrupt without recent event");
  reset_quiet_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(nrst) |-> !host_irq ##1 !host_irq ##1 !host_irq) else $error("interrupt too soon");
  fault_irq_a: assert property (@(posedge mclk) disable iff (!nrst) fault_valid |-> ##[1:10] host_irq)
    else $error("fault not reported");
  xfer_irq_a: assert property (@(posedge mclk) disable iff (!nrst)
    xfer_valid && xfer_kind == 2'h3 && xfer_win <= 3'h4 |-> ##[1:10] host_irq)
    else $error("transfer fault not reported");
  rsp_irq_a: assert property (@(posedge mclk) disable iff (!nrst)
    rsp_valid && rsp_bits != 5'h00 |-> ##[1:10] host_irq) else $error("response not reported");
  window_ready_a: assert property (@(posedge mclk) disable iff (!nrst) acc |-> pready)
    else $error("control window stalled");
  unmapped_err_a: assert property (@(posedge mclk) disable iff (!nrst)
    acc && (paddr > `IOFER_OFF_EVT_COUNT || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (@(posedge mclk) disable iff (!nrst)
    !acc || (paddr <= `IOFER_OFF_EVT_COUNT && paddr[1:0] == 2'h0) |-> !pslverr)
    else $error("spurious error response");
endmodule

// ===== iofer_host_latch.sv
/*
  Host side interrupt latch model with a pulse counter.
  Assumes the handler clears it through latch_clr.
*/
`timescale 1ns/1ns

module iofer_host_latch (
  // Clock and reset
  input  logic       mclk,
  input  logic       nrst,
  // Interrupt side
  input  logic       host_irq,
  input  logic       latch_clr,
  output logic       irq_latched,
  output logic [7:0] pulse_cnt
);
  // latch the pulse
  // A new pulse beats the clear, so a second event is never lost
  always @(posedge mclk) begin
    if (!nrst) begin
      irq_latched <= 1'b0;
      pulse_cnt   <= 8'h00;
    end else begin
      irq_latched <= host_irq | (irq_latched & ~latch_clr);
      pulse_cnt   <= pulse_cnt + {7'h00, host_irq};
    end
  end
endmodule

// ===== test_io_processor_fault_event_report.sv
/*
  Self-checking bench for the fault event reporter.
  Assumes the reporter, its header, the host latch model and the checker.
*/
`timescale 1ns/1ns
`include "iofer_consts.vh"

module test_io_processor_fault_event_report;
  // Stimulus
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        func_done = 1'b0, fault_valid = 1'b0, xfer_valid = 1'b0, rsp_valid = 1'b0;
  logic [5:0]  fault_sel = 6'h00;
  logic [2:0]  xfer_win = 3'h0;
  logic [1:0]  xfer_kind = 2'h0;
  logic [4:0]  rsp_bits = 5'h00;
  logic        latch_clr = 1'b0;
  // Results
  logic        pready, pslverr, host_irq, irq_latched, rerr;
  logic [31:0] prdata, rdat;
  logic [7:0]  pulse_cnt, base_cnt;
  int          n_errors = 0;
  int          n_tests = 0;
  // Row i: fault select i and its expected code
  logic [15:0] codes [0:28] = '{16'h0004, 16'h0005, 16'h0006, 16'h0007, 16'h0008, 16'h0009,
    16'h000A, 16'h000B, 16'h000D, 16'h000C, 16'h000E, 16'h000D, 16'h0013, 16'h0019, 16'h0016,
    16'h0015, 16'h0016, 16'h0015, 16'h0016, 16'h0016, 16'h0019, 16'h6006, 16'h600A, 16'h0031,
    16'h0038, 16'h0031, 16'h6008, 16'h0015, 16'h6017};
  // Window, kind, expected entry state; last two are refused
  logic [14:0] xrows [0:6] = '{{3'h0, 2'h1, 10'h001}, {3'h0, 2'h2, 10'h002},
    {3'h0, 2'h3, 10'h003}, {3'h3, 2'h3, 10'h0C0}, {3'h4, 2'h3, 10'h300},
    {3'h2, 2'h1, 10'h000}, {3'h1, 2'h2, 10'h000}};

  always #25 mclk = ~mclk;

  iofer_reporter dut_u (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .func_done(func_done), .fault_valid(fault_valid), .fault_sel(fault_sel),
    .xfer_valid(xfer_valid), .xfer_win(xfer_win), .xfer_kind(xfer_kind),
    .rsp_valid(rsp_valid), .rsp_bits(rsp_bits), .host_irq(host_irq));
  iofer_host_latch host_u (.mclk(mclk), .nrst(nrst), .host_irq(host_irq),
    .latch_clr(latch_clr), .irq_latched(irq_latched), .pulse_cnt(pulse_cnt));

  task automatic final_report;
    if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    n_tests++;
    if ((got & m) !== (exp & m)) begin
      n_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got & m, exp & m);
    end
  endtask

  // Called just after a rising edge; holds the request until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // Ends the strobe set by the caller, then checks and clears the latch
  task automatic fire(input logic e, input logic en);
    @(posedge mclk);
    {func_done, fault_valid, xfer_valid, rsp_valid} <= 4'h0;
    repeat (8) @(posedge mclk);
    chk({31'h0, irq_latched}, {31'h0, e}, {31'h0, en});
    latch_clr <= 1'b1;
    @(posedge mclk);
    latch_clr <= 1'b0;
  endtask

  function automatic logic [1:0] lvl(input logic [1:0] t);
    lvl = (t == 2'h0) ? 2'h1 : ((t == 2'h3) ? 2'h3 : 2'h2);
  endfunction

  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    apb(1'b0, `IOFER_OFF_FUNC_STATE, 32'h0);
    chk(rdat, 32'hF, 32'hF);
    chk({31'h0, rerr}, 32'h0, 32'h1);
    apb(1'b0, `IOFER_OFF_ENTRY_STATE, 32'h0);
    chk(rdat, 32'h0, 32'h3FF);
    apb(1'b0, `IOFER_OFF_RESP, 32'h0);
    chk(rdat, 32'h0, 32'h1F);
    for (int i = 0; i < 29; i++) begin
      fault_sel <= i[5:0];
      fault_valid <= 1'b1;
      fire(1'b1, 1'b1);
      apb(1'b0, `IOFER_OFF_FAULT_CODE, 32'h0);
      chk(rdat, {16'h0, codes[i]}, 32'h60FF);
      if (codes[i][14:13] == 2'h0) begin
        apb(1'b0, `IOFER_OFF_FUNC_STATE, 32'h0);
        chk(rdat, {30'h0, lvl(codes[i][5:4])}, 32'hF);
      end
    end
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, `IOFER_OFF_FUNC_STATE, 32'h1);
      apb(1'b1, `IOFER_OFF_CTRL, m);
      func_done <= 1'b1;
      fire(m == 0, 1'b1);
      apb(1'b0, `IOFER_OFF_FUNC_STATE, 32'h0);
      chk(rdat, (m == 0) ? 32'h0 : 32'hF, 32'hF);
    end
    apb(1'b1, `IOFER_OFF_CTRL, 32'h0);
    for (int i = 0; i < 7; i++) begin
      {xfer_win, xfer_kind} <= xrows[i][14:10];
      xfer_valid <= 1'b1;
      fire(1'b1, xrows[i][9:0] != 10'h000);
      apb(1'b0, `IOFER_OFF_ENTRY_STATE, 32'h0);
      chk(rdat, {22'h0, xrows[i][9:0]}, 32'h3FF);
      apb(1'b1, `IOFER_OFF_ENTRY_STATE, 32'h3FF);
    end
    for (int i = 0; i < 5; i++) begin
      rsp_bits <= 5'h01 << i;
      rsp_valid <= 1'b1;
      fire(1'b1, 1'b1);
      apb(1'b0, `IOFER_OFF_RESP, 32'h0);
      chk(rdat, 32'h1 << i, 32'h1F);
      apb(1'b1, `IOFER_OFF_RESP, 32'h1F);
    end
    base_cnt = pulse_cnt;
    fault_sel <= `IOFER_F_MAP_DIR;
    fault_valid <= 1'b1;
    @(posedge mclk);
    fault_valid <= 1'b0;
    // Response lands on the commit edge of the fault, so it needs its own pulse
    @(posedge mclk);
    rsp_bits <= 5'h02;
    rsp_valid <= 1'b1;
    fire(1'b1, 1'b1);
    repeat (4) @(posedge mclk);
    chk({24'h0, pulse_cnt - base_cnt}, 32'h2, 32'hFF);
    apb(1'b0, `IOFER_OFF_RESP, 32'h0);
    chk(rdat, 32'h2, 32'h1F);
    apb(1'b0, `IOFER_OFF_FAULT_CODE, 32'h0);
    chk(rdat, 32'h6, 32'h60FF);
    apb(1'b1, 12'h018, 32'hFFFF_FFFF);
    chk({31'h0, rerr}, 32'h1, 32'h1);
    final_report;
  end

  initial begin
    repeat (6000) @(posedge mclk);
    n_errors++;
    final_report;
  end
endmodule

bind iofer_reporter iofer_reporter_monitor mon_u (.mclk(mclk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .func_done(func_done), .fault_valid(fault_valid),
  .fault_sel(fault_sel), .xfer_valid(xfer_valid), .xfer_win(xfer_win),
  .xfer_kind(xfer_kind), .rsp_valid(rsp_valid), .rsp_bits(rsp_bits), .host_irq(host_irq));
